// [common/bld_consts.svh]
`ifndef BLD_CONSTS_SVH
`define BLD_CONSTS_SVH
// =====================================================
// register byte offsets
`define BLD_OFF_CFG     8'h00
`define BLD_OFF_CTRL    8'h04
`define BLD_OFF_STAT    8'h08
`define BLD_OFF_THR     8'h0C
// =====================================================
// cfg field positions
`define BLD_CFG_USE     0
`define BLD_CFG_POL     1
`define BLD_CFG_PWR_LO  2
`define BLD_CFG_PWR_HI  3
`define BLD_CFG_DL_LO   4
`define BLD_CFG_DL_HI   5
// ctrl field positions
`define BLD_CTRL_DIS    0
`define BLD_CTRL_NVLOAD 1
// =====================================================
// start-up codes
`define BLD_SU_OFF      2'h0
`define BLD_SU_ON       2'h1
`define BLD_SU_PREV     2'h2
// =====================================================
// reset values and answers
`define BLD_ZERO32      32'h0000_0000
`define BLD_RESP_OKAY   2'h0
`define BLD_RESP_SLVERR 2'h2
`endif

// [common/bld_pkg.sv]
package bld_pkg;
    typedef enum logic [1:0] {
        BLD_ST_BOOT,
        BLD_ST_RUN
    } bld_state_t;

    typedef struct packed {
        logic        pwr_fail;
        logic        dl_done;
        logic        nv_state;
    } bld_sys_t;

    typedef struct packed {
        logic [7:0]  lower;
        logic [7:0]  upper;
    } bld_thr_t;
endpackage

// [core/bld_core.sv]
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Contract
// - power-up start-up off: evaluation runs at once on supply return.
// - if enabled, an output sends above upper or below lower threshold.
// - power-up start-up on: all limits disabled, nothing is sent; here cfg is clear at boot, so nothing is disabled.
// - on supply loss the present disable state is saved first.
// - power-up start-up previous: the saved state is restored; here cfg is clear at boot, so nv_state is never read.
// - download start-up off: evaluation runs at once after a download.
// - download start-up on: all limits disabled, nothing is sent.
// - start-up settings apply only when the disabling function is used.
// - one bus bit disables or enables, with configurable polarity.
// - while disabled no telegrams go out, yet presets are still taken.
`include "bld_consts.svh"
module bld_core
    import bld_pkg::*;
#(
    parameter int N_OUT = 4
) (
    input  wire logic               clock,
    input  wire logic               nrst,
    input  wire logic               clk_en,
    // axi4-lite slave
    input  wire logic [7:0]         s_awaddr,
    input  wire logic               s_awvalid,
    output logic                    s_awready,
    input  wire logic [31:0]        s_wdata,
    input  wire logic [3:0]         s_wstrb,
    input  wire logic               s_wvalid,
    output logic                    s_wready,
    output logic [1:0]              s_bresp,
    output logic                    s_bvalid,
    input  wire logic               s_bready,
    input  wire logic [7:0]         s_araddr,
    input  wire logic               s_arvalid,
    output logic                    s_arready,
    output logic [31:0]             s_rdata,
    output logic [1:0]              s_rresp,
    output logic                    s_rvalid,
    input  wire logic               s_rready,
    // system events, same clock
    input  wire bld_sys_t           sys_in,
    output logic                    nv_wr,
    output logic                    nv_wdata,
    // brightness and presets
    input  wire logic [7:0]         bright,
    input  wire logic               preset_vld,
    input  wire logic [$clog2(N_OUT)-1:0] preset_idx,
    input  wire bld_thr_t           preset_thr,
    // per-output telegram strobes
    output logic [N_OUT-1:0]        tx_above,
    output logic [N_OUT-1:0]        tx_below
);
    // =====================================================
    // registers
    localparam int IW = $clog2(N_OUT);

    bld_state_t        st_q;
    bld_state_t        st_d;
    logic [5:0]        cfg_q;
    logic              dis_bit_q;
    logic              dis_q;
    logic              dis_d;
    logic              nv_wr_d;
    logic              nv_wdata_d;
    bld_thr_t          thr_q [N_OUT];
    logic [N_OUT-1:0]  above_q;
    logic [N_OUT-1:0]  below_q;
    logic [N_OUT-1:0]  tx_above_d;
    logic [N_OUT-1:0]  tx_below_d;
    wire  [N_OUT-1:0]  hi_w;
    wire  [N_OUT-1:0]  lo_w;

    // =====================================================
    // decoding helpers
    function automatic logic su_dis(
        input logic [1:0] code,
        input logic       saved
    );
        case (code)
            `BLD_SU_ON:   su_dis = 1'b1;
            `BLD_SU_PREV: su_dis = saved;
            default:      su_dis = 1'b0;
        endcase
    endfunction

    function automatic logic any_set(
        input logic [N_OUT-1:0] a,
        input logic [N_OUT-1:0] b
    );
        return |(a | b);
    endfunction

    // polarity bit set means a zero on the bus disables
    function automatic logic pol_dis(
        input logic raw,
        input logic pol
    );
        return raw ^ pol;
    endfunction

    // =====================================================
    // bus decode
    wire        wr_go   = s_awvalid && s_wvalid && !s_bvalid;
    wire        rd_go   = s_arvalid && !s_rvalid;
    wire        wr_take = wr_go && !s_awready;
    wire        rd_take = rd_go && !s_arready;
    wire        w_cfg   = wr_take && s_awaddr == `BLD_OFF_CFG;
    wire        w_ctrl  = wr_take && s_awaddr == `BLD_OFF_CTRL;
    wire        w_ok    = w_cfg || w_ctrl;
    wire        r_cfg   = s_araddr == `BLD_OFF_CFG;
    wire        r_ctrl  = s_araddr == `BLD_OFF_CTRL;
    wire        r_stat  = s_araddr == `BLD_OFF_STAT;
    wire        r_ok    = r_cfg || r_ctrl || r_stat;
    wire        running = st_q == BLD_ST_RUN;
    wire        beyond  = any_set(above_q, below_q);
    wire [31:0] r_mux   =
        r_cfg  ? {26'h000_0000, cfg_q} :
        r_ctrl ? {31'h0000_0000, dis_bit_q} :
        r_stat ? {29'h0000_0000, running, beyond, dis_q} :
        `BLD_ZERO32;

    // =====================================================
    // configuration fields
    wire [31:0] wd       = s_wdata;
    wire [5:0]  cfg_new  = wd[`BLD_CFG_DL_HI:`BLD_CFG_USE];
    wire        use_fn   = cfg_q[`BLD_CFG_USE];
    wire        pol      = cfg_q[`BLD_CFG_POL];
    wire [1:0]  pwr_code = cfg_q[`BLD_CFG_PWR_HI:`BLD_CFG_PWR_LO];
    wire [1:0]  dl_code  = cfg_q[`BLD_CFG_DL_HI:`BLD_CFG_DL_LO];
    wire        dis_new  = pol_dis(wd[`BLD_CTRL_DIS], pol);
    // a new polarity or use setting re-reads the stored bus bit
    wire        cfg_dis  = cfg_new[`BLD_CFG_USE]
                        && pol_dis(dis_bit_q, cfg_new[`BLD_CFG_POL]);
    // cfg is cleared by reset too, so power start-up codes never act:
    // boot only follows a reset and always reads the cleared cfg
    wire boot_dis = use_fn && su_dis(pwr_code, sys_in.nv_state);
    wire dl_dis   = use_fn && su_dis(dl_code, 1'b0);
    wire evaluate = running && !dis_q && !sys_in.pwr_fail;

    // =====================================================
    // start-up and disable state
    always_comb begin
        st_d  = st_q;
        dis_d = dis_q;
        case (st_q)
            BLD_ST_BOOT: begin
                // nv_state masked by the cleared cfg; no evaluation before this
                dis_d = boot_dis;
                st_d  = BLD_ST_RUN;
            end
            BLD_ST_RUN: begin
                if (sys_in.dl_done) begin
                    dis_d = dl_dis;
                end else if (w_cfg) begin
                    dis_d = cfg_dis;
                end else if (w_ctrl && use_fn) begin
                    dis_d = dis_new;
                end else if (!use_fn) begin
                    dis_d = 1'b0;
                end
            end
            default: begin
                st_d = BLD_ST_BOOT;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_q  <= BLD_ST_BOOT;
            dis_q <= 1'b0;
        end else if (clk_en) begin
            st_q  <= st_d;
            dis_q <= dis_d;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            cfg_q     <= '0;
            dis_bit_q <= 1'b0;
        end else if (clk_en) begin
            if (w_cfg) begin
                cfg_q <= cfg_new;
            end
            if (w_ctrl) begin
                dis_bit_q <= wd[`BLD_CTRL_DIS];
            end
        end
    end

    // =====================================================
    // state save on a failing supply
    // written every cycle of the failure, so the last word stored wins
    assign nv_wr_d    = sys_in.pwr_fail;
    assign nv_wdata_d = dis_q;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            nv_wr    <= 1'b0;
            nv_wdata <= 1'b0;
        end else if (clk_en) begin
            nv_wr    <= nv_wr_d;
            nv_wdata <= nv_wdata_d;
        end
    end

    // =====================================================
    // threshold evaluation, one lane per output
    genvar gi;
    generate
        for (gi = 0; gi < N_OUT; gi++) begin : g_out
            wire hit_pre = preset_vld && preset_idx == IW'(gi);
            assign hi_w[gi] = bright > thr_q[gi].upper;
            assign lo_w[gi] = bright < thr_q[gi].lower;
            // presets land even while disabled
            always_ff @(posedge clock) begin
                if (!nrst) begin
                    thr_q[gi] <= '0;
                end else if (clk_en && hit_pre) begin
                    thr_q[gi] <= preset_thr;
                end
            end
        end
    endgenerate

    // sends on entry into the region only, so a steady level stays quiet
    assign tx_above_d = {N_OUT{evaluate}} & hi_w & ~above_q;
    assign tx_below_d = {N_OUT{evaluate}} & lo_w & ~below_q;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            above_q  <= '0;
            below_q  <= '0;
            tx_above <= '0;
            tx_below <= '0;
        end else if (clk_en) begin
            above_q  <= hi_w;
            below_q  <= lo_w;
            tx_above <= tx_above_d;
            tx_below <= tx_below_d;
        end
    end

    // =====================================================
    // write channel: ready and answer together, the cycle after the take
    wire       b_done = s_bvalid && s_bready;
    wire [1:0] b_code = w_ok ? `BLD_RESP_OKAY : `BLD_RESP_SLVERR;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
        end else if (clk_en) begin
            s_awready <= wr_take;
            s_wready  <= wr_take;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            s_bvalid <= 1'b0;
            s_bresp  <= `BLD_RESP_OKAY;
        end else if (clk_en) begin
            if (wr_take) begin
                s_bvalid <= 1'b1;
                s_bresp  <= b_code;
            end else if (b_done) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // =====================================================
    // read channel: data captured at the take edge and held
    wire       r_done = s_rvalid && s_rready;
    wire [1:0] r_code = r_ok ? `BLD_RESP_OKAY : `BLD_RESP_SLVERR;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            s_arready <= 1'b0;
        end else if (clk_en) begin
            s_arready <= rd_take;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            s_rvalid <= 1'b0;
            s_rdata  <= `BLD_ZERO32;
            s_rresp  <= `BLD_RESP_OKAY;
        end else if (clk_en) begin
            if (rd_take) begin
                s_rvalid <= 1'b1;
                s_rdata  <= r_mux;
                s_rresp  <= r_code;
            end else if (r_done) begin
                s_rvalid <= 1'b0;
            end
        end
    end
endmodule // bld_core

// [verification/bld_core_monitor.sv]
`timescale 1ns/1ps
module bld_core_mon
    import bld_pkg::*;
#(
    parameter int N_OUT = 4
) (
    input wire logic             clock,
    input wire logic             nrst,
    input wire logic             s_awready,
    input wire logic             s_wready,
    input wire logic             s_bvalid,
    input wire logic             s_bready,
    input wire logic             s_arready,
    input wire logic             s_rvalid,
    input wire logic             s_rready,
    input wire logic [31:0]      s_rdata,
    input wire bld_sys_t         sys_in,
    input wire logic             nv_wr,
    input wire logic [N_OUT-1:0] tx_above,
    input wire logic [N_OUT-1:0] tx_below
);
// ==========
// checks
default clocking cb @(posedge clock); endclocking
default disable iff (!nrst);
chk_nv_save: assert property (sys_in.pwr_fail |=> nv_wr)
    else $error("state not saved on supply loss");
chk_tx_stop: assert property (sys_in.pwr_fail && $past(sys_in.pwr_fail)
    |-> !(|{tx_above, tx_below}))
    else $error("telegram during supply loss");
chk_tx_excl: assert property (!(|(tx_above & tx_below)))
    else $error("above and below at once");
chk_tx_pulse: assert property (!(|(tx_above & $past(tx_above))))
    else $error("telegram repeated");
chk_b_hold: assert property (s_bvalid && !s_bready |=> s_bvalid)
    else $error("write answer dropped");
chk_r_hold: assert property (s_rvalid && !s_rready
    |=> s_rvalid && $stable(s_rdata))
    else $error("read answer dropped");
chk_w_ready: assert property (s_awready |-> s_wready && s_bvalid)
    else $error("write ready without answer");
chk_r_ready: assert property (s_arready |-> s_rvalid)
    else $error("read ready without answer");
cover property (|tx_above);
cover property (nv_wr);
cover property (s_bvalid && s_bready);
endmodule // bld_core_mon

bind bld_core bld_core_mon #(.N_OUT(N_OUT)) u_mon (.clock, .nrst,
    .s_awready, .s_wready, .s_bvalid, .s_bready, .s_arready, .s_rvalid,
    .s_rready, .s_rdata, .sys_in, .nv_wr, .tx_above, .tx_below);

// [verification/bld_bus_dev.sv]
`timescale 1ns/1ps
// ==========
// far-side devices: brightness source and telegram listeners
module bld_bus_dev (
    input wire logic       clock,
    input wire logic [7:0] lvl,
    input wire logic [3:0] above,
    input wire logic [3:0] below,
    output logic [7:0]     bright,
    output int             n_above,
    output int             n_below
);
initial begin
    n_above = 0;
    n_below = 0;
    bright = 8'h00;
end
// counts set strobe bits every cycle, so a level held high shows up as a fault
always @(posedge clock) begin
    bright <= lvl;
    n_above <= n_above + $countones(above);
    n_below <= n_below + $countones(below);
end
endmodule // bld_bus_dev

// [verification/bld_core_tb.sv]
`timescale 1ns/1ps
module bld_core_tb
    import bld_pkg::*;
;
logic        clock, nrst, clk_en, s_awvalid, s_wvalid, s_bready;
logic        s_arvalid, s_rready, preset_vld;
logic [7:0]  s_awaddr, s_araddr, lvl;
logic [31:0] s_wdata, rd_d;
logic [3:0]  s_wstrb;
logic [1:0]  preset_idx, resp;
bld_sys_t    sys_in;
bld_thr_t    preset_thr;
wire         s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
wire         nv_wr, nv_wdata;
wire [1:0]   s_bresp, s_rresp;
wire [31:0]  s_rdata;
wire [7:0]   bright;
wire [3:0]   tx_above, tx_below;
int          errors = 0, checks = 0, cyc = 0, na, nb;
bld_core #(.N_OUT(4)) u_dut (.clock, .nrst, .clk_en, .s_awaddr,
    .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .sys_in, .nv_wr, .nv_wdata,
    .bright, .preset_vld, .preset_idx, .preset_thr, .tx_above, .tx_below);
bld_bus_dev u_dev (.clock, .lvl, .above(tx_above), .below(tx_below),
    .bright, .n_above(na), .n_below(nb));
// ==========
// tasks
task automatic results();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
endtask
task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
        errors++;
        $display("wrong value t=%0t seen=%h exp=%h", $time, s, e);
    end
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    {s_awaddr, s_wdata} <= {a, d};
    {s_awvalid, s_wvalid, s_bready} <= 3'h7;
    do @(posedge clock); while (!s_bvalid);
    resp = s_bresp;
    {s_awvalid, s_wvalid, s_bready} <= 3'h0;
endtask
task automatic rd(input logic [7:0] a);
    @(posedge clock);
    s_araddr <= a;
    {s_arvalid, s_rready} <= 2'h3;
    do @(posedge clock); while (!s_rvalid);
    rd_d = s_rdata;
    resp = s_rresp;
    {s_arvalid, s_rready} <= 2'h0;
endtask
task automatic st(input logic dis);
    rd(8'h08);
    chk(32'(rd_d[0]), 32'(dis));
endtask
task automatic pr(input logic [7:0] up);
    for (int i = 0; i < 4; i++) begin
        @(posedge clock);
        preset_vld <= 1'h1;
        preset_idx <= 2'(i);
        preset_thr <= {8'h28, up};
    end
    @(posedge clock);
    preset_vld <= 1'h0;
endtask
task automatic dl();
    @(posedge clock);
    sys_in.dl_done <= 1'h1;
    @(posedge clock);
    sys_in.dl_done <= 1'h0;
endtask
// start mid-band so only crossings made here are counted
task automatic sw(input int ea, input int eb);
    int a0;
    int b0;
    @(posedge clock);
    lvl <= 8'h3c;
    repeat (6) @(posedge clock);
    a0 = na;
    b0 = nb;
    lvl <= 8'h64;
    repeat (6) @(posedge clock);
    lvl <= 8'h14;
    repeat (6) @(posedge clock);
    chk(na - a0, ea);
    chk(nb - b0, eb);
endtask
// ==========
// run
initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
end
always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
        errors++;
        results();
    end
end
initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wdata, lvl, rd_d, resp} = '0;
    {sys_in, preset_vld, preset_idx, preset_thr, nrst} = '0;
    clk_en = 1'h1;
    s_wstrb = 4'hf;
    repeat (2) @(posedge clock);
    nrst <= 1'h1;
    pr(8'h50);
    rd(8'h00);
    chk(rd_d, 32'h0000_0000);
    rd(8'h08);
    chk(32'(rd_d[2]), 32'h0000_0001);
    sw(4, 4);
    wr(8'h00, 32'h0000_0001);
    wr(8'h04, 32'h0000_0001);
    st(1'h1);
    pr(8'h70);
    sw(0, 0);
    wr(8'h00, 32'h0000_0003);
    st(1'h0);
    sw(0, 4);
    pr(8'h50);
    wr(8'h00, 32'h0000_0010);
    dl();
    st(1'h0);
    wr(8'h00, 32'h0000_0011);
    wr(8'h04, 32'h0000_0000);
    dl();
    st(1'h1);
    sw(0, 0);
    wr(8'h00, 32'h0000_0001);
    dl();
    st(1'h0);
    sw(4, 4);
    wr(8'h04, 32'h0000_0001);
    @(posedge clock);
    sys_in.pwr_fail <= 1'h1;
    repeat (3) @(posedge clock);
    #1;
    chk(32'(nv_wr), 32'h0000_0001);
    chk(32'(nv_wdata), 32'h0000_0001);
    @(posedge clock);
    sys_in.pwr_fail <= 1'h0;
    // second reset in mid-run: cfg clears, so evaluation restarts at once
    @(posedge clock);
    nrst <= 1'h0;
    repeat (2) @(posedge clock);
    nrst <= 1'h1;
    rd(8'h00);
    chk(rd_d, 32'h0000_0000);
    st(1'h0);
    pr(8'h50);
    sw(4, 4);
    wr(8'h20, 32'h0000_0001);
    chk(32'(resp), 32'h0000_0002);
    rd(8'h20);
    chk(32'(resp), 32'h0000_0002);
    results();
end
endmodule // bld_core_tb
